// [gas_out_pkg.sv]
// shared constants, register map and types for the gas reading output control block
package gas_out_pkg;

    // timing
    localparam int unsigned CLK_HZ       = 250_000_000;
    localparam int unsigned WARMUP_S     = 45;
    localparam int unsigned BAUD_FAST    = 38400;
    localparam int unsigned BIT_DIV_FAST = CLK_HZ / BAUD_FAST;

    // register byte offsets
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_WARM_LVL  = 12'h004;
    localparam logic [11:0] OFS_WARM_SECS = 12'h008;
    localparam logic [11:0] OFS_ZERO_CODE = 12'h00c;
    localparam logic [11:0] OFS_GAIN      = 12'h010;
    localparam logic [11:0] OFS_STATUS    = 12'h014;
    localparam logic [11:0] OFS_READING   = 12'h018;
    localparam logic [11:0] OFS_CAL       = 12'h01c;

    // field positions
    localparam int unsigned CTRL_W       = 5;
    localparam int unsigned ST_ZERO_BIT  = 8;
    localparam int unsigned ST_SPAN_BIT  = 9;

    // reset values
    localparam logic [4:0]  CTRL_RST      = 5'h00;
    localparam logic [15:0] WARM_SECS_RST = 16'(WARMUP_S);
    localparam logic [15:0] ZERO_CODE_RST = 16'h0800;
    localparam logic [15:0] GAIN_RST      = 16'h0400;

    // readings in tenths of a percent of full_scale_reading, signed
    localparam logic [15:0] SENTINEL  = 16'hf63c;
    localparam logic [15:0] LIMIT_100 = 16'h03e8;
    localparam logic [15:0] LIMIT_125 = 16'h04e2;
    localparam logic [15:0] LIMIT_150 = 16'h05dc;
    localparam logic [15:0] LIMIT_200 = 16'h07d0;
    localparam int unsigned GAIN_SHIFT = 10;

    // serial commands
    localparam logic [7:0] CMD_READ = 8'h01;
    localparam logic [7:0] CMD_ZERO = 8'h02;
    localparam logic [7:0] CMD_SPAN = 8'h03;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef struct packed {
        logic analog_bad;
        logic supply_bad;
        logic memory_bad;
    } health_s;

    typedef struct packed {
        logic [1:0] baud_sel;
        logic [1:0] over_sel;
        logic       falling;
    } ctrl_s;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;

endpackage

// [gas_reading_output_control.sv]
// gas reading output control: warm-up hold, freeze, clamp, fault override, uart, apb
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module gas_reading_output_control #(
    parameter int unsigned SEC_CYCLES = gas_out_pkg::CLK_HZ,
    parameter int unsigned BIT_CYCLES = gas_out_pkg::BIT_DIV_FAST
) (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // sensor side
    input  wire logic [15:0]          calc_reading,
    input  wire logic                 transient,
    input  wire gas_out_pkg::health_s health,
    // outputs and the uart receive input
    output logic      [15:0]          analog_code,
    input  wire logic                 rx_line,
    output logic                      tx_line
);

    // one bit time in cycles for a baud select; each slower rate doubles the divisor of the one before
    function automatic logic [19:0] bit_period(input logic [1:0] sel);
        bit_period = 20'(BIT_CYCLES) << sel;
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == gas_out_pkg::OFS_CTRL) || (a == gas_out_pkg::OFS_WARM_LVL) ||
                 (a == gas_out_pkg::OFS_WARM_SECS) || (a == gas_out_pkg::OFS_ZERO_CODE) ||
                 (a == gas_out_pkg::OFS_GAIN) || (a == gas_out_pkg::OFS_STATUS) ||
                 (a == gas_out_pkg::OFS_READING) || (a == gas_out_pkg::OFS_CAL);
    endfunction

    gas_out_pkg::ctrl_s ctrl;
    logic [15:0]        warm_level;
    logic [15:0]        warm_secs;
    logic [15:0]        zero_code;
    logic [15:0]        gain;
    logic               zero_flag;
    logic               span_flag;
    logic [15:0]        zero_ref;
    logic [15:0]        span_ref;
    logic [31:0]        sec_cnt;
    logic [15:0]        secs_done;
    logic               warming;
    logic               fault;
    logic [15:0]        limit;
    logic [15:0]        clamped;
    logic               clamping;
    logic [15:0]        held;
    logic [15:0]        live;
    logic [15:0]        serial_reading;
    logic signed [32:0] product;
    logic signed [32:0] next_code;
    logic               wr;
    logic               rd;
    logic               zero_set;
    logic               span_set;
    logic               read_req;

    assign wr      = psel && penable && pwrite;
    assign rd      = psel && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);

    // warm-up timing from reset release; a shorter programmed time takes effect at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt   <= 32'h0;
            secs_done <= 16'h0;
        end else if (warming) begin
            if (sec_cnt == SEC_CYCLES - 1) begin
                sec_cnt   <= 32'h0;
                secs_done <= secs_done + 16'h1;
            end else begin
                sec_cnt <= sec_cnt + 32'h1;
            end
        end
    end
    assign warming = secs_done < warm_secs;

    assign fault = health.memory_bad | health.supply_bad | health.analog_bad;

    always_comb begin
        case (ctrl.over_sel)
            2'h0:    limit = gas_out_pkg::LIMIT_100;
            2'h1:    limit = gas_out_pkg::LIMIT_125;
            2'h2:    limit = gas_out_pkg::LIMIT_150;
            default: limit = gas_out_pkg::LIMIT_200;
        endcase
    end
    // signed compare keeps the negative readings of early warm-up intact
    assign clamping = $signed(calc_reading) > $signed(limit);
    assign clamped  = clamping ? limit : calc_reading;

    // hold only refreshes outside a transient, so freeze shows the last settled value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held <= 16'h0;
        end else if (!transient) begin
            held <= clamped;
        end
    end
    assign live = transient ? held : clamped;

    // analogue scaling, saturated to the converter range
    assign product = 33'($signed(live)) * 33'($signed({1'b0, gain}));
    always_comb begin
        if (ctrl.falling) begin
            next_code = 33'($signed({1'b0, zero_code})) - (product >>> gas_out_pkg::GAIN_SHIFT);
        end else begin
            next_code = 33'($signed({1'b0, zero_code})) + (product >>> gas_out_pkg::GAIN_SHIFT);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_code <= gas_out_pkg::ZERO_CODE_RST;
        end else if (fault) begin
            analog_code <= 16'h0000;
        end else if (warming) begin
            analog_code <= warm_level;
        end else if (next_code < 0) begin
            analog_code <= 16'h0000;
        end else if (next_code > 33'sh0ffff) begin
            analog_code <= 16'hffff;
        end else begin
            analog_code <= next_code[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_reading <= gas_out_pkg::SENTINEL;
        end else if (fault || warming) begin
            serial_reading <= gas_out_pkg::SENTINEL;
        end else begin
            serial_reading <= live;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl       <= gas_out_pkg::CTRL_RST;
            warm_level <= gas_out_pkg::ZERO_CODE_RST;
            warm_secs  <= gas_out_pkg::WARM_SECS_RST;
            zero_code  <= gas_out_pkg::ZERO_CODE_RST;
            gain       <= gas_out_pkg::GAIN_RST;
        end else if (wr) begin
            case (paddr)
                gas_out_pkg::OFS_CTRL:      ctrl       <= pwdata[gas_out_pkg::CTRL_W-1:0];
                gas_out_pkg::OFS_WARM_LVL:  warm_level <= pwdata[15:0];
                gas_out_pkg::OFS_WARM_SECS: warm_secs  <= pwdata[15:0];
                gas_out_pkg::OFS_ZERO_CODE: zero_code  <= pwdata[15:0];
                gas_out_pkg::OFS_GAIN:      gain       <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // calibration capture; a new command in the clear cycle keeps its flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_flag <= 1'b0;
            span_flag <= 1'b0;
            zero_ref  <= 16'h0;
            span_ref  <= 16'h0;
        end else begin
            zero_flag <= zero_set | (zero_flag &
                         ~(wr && paddr == gas_out_pkg::OFS_STATUS && pwdata[gas_out_pkg::ST_ZERO_BIT]));
            span_flag <= span_set | (span_flag &
                         ~(wr && paddr == gas_out_pkg::OFS_STATUS && pwdata[gas_out_pkg::ST_SPAN_BIT]));
            if (zero_set) begin
                zero_ref <= calc_reading;
            end
            if (span_set) begin
                span_ref <= calc_reading;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd && !penable) begin
            case (paddr)
                gas_out_pkg::OFS_CTRL:      prdata <= {27'h0, ctrl};
                gas_out_pkg::OFS_WARM_LVL:  prdata <= {16'h0, warm_level};
                gas_out_pkg::OFS_WARM_SECS: prdata <= {16'h0, warm_secs};
                gas_out_pkg::OFS_ZERO_CODE: prdata <= {16'h0, zero_code};
                gas_out_pkg::OFS_GAIN:      prdata <= {16'h0, gain};
                gas_out_pkg::OFS_STATUS:    prdata <= {22'h0, span_flag, zero_flag, 4'h0,
                                                       clamping, transient, fault, warming};
                gas_out_pkg::OFS_READING:   prdata <= {16'h0, serial_reading};
                gas_out_pkg::OFS_CAL:       prdata <= {span_ref, zero_ref};
                default:                    prdata <= 32'h0;
            endcase
        end
    end

    // uart receiver, mid-bit sampling
    gas_out_pkg::rx_state_e rx_state;
    logic [19:0]            rx_cnt;
    logic [2:0]             rx_bit;
    logic [7:0]             rx_shift;
    logic                   rx_done;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= gas_out_pkg::RX_IDLE;
            rx_cnt   <= 20'h0;
            rx_bit   <= 3'h0;
            rx_shift <= 8'h0;
            rx_done  <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            case (rx_state)
                gas_out_pkg::RX_IDLE: begin
                    rx_cnt <= bit_period(ctrl.baud_sel) >> 1;
                    if (!rx_line) begin
                        rx_state <= gas_out_pkg::RX_START;
                    end
                end
                gas_out_pkg::RX_START: begin
                    if (rx_cnt != 20'h0) begin
                        rx_cnt <= rx_cnt - 20'h1;
                    end else if (rx_line) begin
                        rx_state <= gas_out_pkg::RX_IDLE; // glitch, not a start bit
                    end else begin
                        rx_cnt   <= bit_period(ctrl.baud_sel) - 20'h1;
                        rx_bit   <= 3'h0;
                        rx_state <= gas_out_pkg::RX_DATA;
                    end
                end
                gas_out_pkg::RX_DATA: begin
                    if (rx_cnt != 20'h0) begin
                        rx_cnt <= rx_cnt - 20'h1;
                    end else begin
                        rx_shift <= {rx_line, rx_shift[7:1]};
                        rx_cnt   <= bit_period(ctrl.baud_sel) - 20'h1;
                        rx_bit   <= rx_bit + 3'h1;
                        if (rx_bit == gas_out_pkg::LAST_BIT) begin
                            rx_state <= gas_out_pkg::RX_STOP;
                        end
                    end
                end
                gas_out_pkg::RX_STOP: begin
                    if (rx_cnt != 20'h0) begin
                        rx_cnt <= rx_cnt - 20'h1;
                    end else begin
                        rx_done  <= rx_line; // bad stop bit drops the byte
                        rx_state <= gas_out_pkg::RX_IDLE;
                    end
                end
                default: rx_state <= gas_out_pkg::RX_IDLE;
            endcase
        end
    end

    assign zero_set = rx_done && rx_shift == gas_out_pkg::CMD_ZERO;
    assign span_set = rx_done && rx_shift == gas_out_pkg::CMD_SPAN;
    assign read_req = rx_done && rx_shift == gas_out_pkg::CMD_READ;

    // uart transmitter: reading goes out low byte then high byte
    gas_out_pkg::tx_state_e tx_state;
    logic [19:0]            tx_cnt;
    logic [2:0]             tx_bit;
    logic [7:0]             tx_shift;
    logic [7:0]             tx_high;
    logic                   tx_second;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state  <= gas_out_pkg::TX_IDLE;
            tx_cnt    <= 20'h0;
            tx_bit    <= 3'h0;
            tx_shift  <= 8'h0;
            tx_high   <= 8'h0;
            tx_second <= 1'b0;
            tx_line   <= 1'b1;
        end else begin
            case (tx_state)
                gas_out_pkg::TX_IDLE: begin
                    tx_line <= 1'b1;
                    if (read_req) begin
                        // snapshot both bytes so they belong to one reading
                        tx_shift  <= serial_reading[7:0];
                        tx_high   <= serial_reading[15:8];
                        tx_second <= 1'b1;
                        tx_line   <= 1'b0;
                        tx_cnt    <= bit_period(ctrl.baud_sel) - 20'h1;
                        tx_state  <= gas_out_pkg::TX_START;
                    end
                end
                gas_out_pkg::TX_START: begin
                    if (tx_cnt != 20'h0) begin
                        tx_cnt <= tx_cnt - 20'h1;
                    end else begin
                        tx_line  <= tx_shift[0];
                        tx_shift <= tx_shift >> 1;
                        tx_bit   <= 3'h0;
                        tx_cnt   <= bit_period(ctrl.baud_sel) - 20'h1;
                        tx_state <= gas_out_pkg::TX_DATA;
                    end
                end
                gas_out_pkg::TX_DATA: begin
                    if (tx_cnt != 20'h0) begin
                        tx_cnt <= tx_cnt - 20'h1;
                    end else begin
                        tx_cnt <= bit_period(ctrl.baud_sel) - 20'h1;
                        if (tx_bit == gas_out_pkg::LAST_BIT) begin
                            tx_line  <= 1'b1;
                            tx_state <= gas_out_pkg::TX_STOP;
                        end else begin
                            tx_line  <= tx_shift[0];
                            tx_shift <= tx_shift >> 1;
                            tx_bit   <= tx_bit + 3'h1;
                        end
                    end
                end
                gas_out_pkg::TX_STOP: begin
                    if (tx_cnt != 20'h0) begin
                        tx_cnt <= tx_cnt - 20'h1;
                    end else if (tx_second) begin
                        tx_second <= 1'b0;
                        tx_shift  <= tx_high;
                        tx_line   <= 1'b0;
                        tx_cnt    <= bit_period(ctrl.baud_sel) - 20'h1;
                        tx_state  <= gas_out_pkg::TX_START;
                    end else begin
                        tx_state <= gas_out_pkg::TX_IDLE;
                    end
                end
                default: tx_state <= gas_out_pkg::TX_IDLE;
            endcase
        end
    end

endmodule

// [gas_out_monitor.sv]
// port checker for the gas reading output control block
`timescale 1ns/1ps
module gas_out_monitor #(
    parameter int unsigned SEC_CYCLES = 100,
    parameter int unsigned BIT_CYCLES = 16
) (
    // clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // apb
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // sensor side, outputs and the uart receive input
    input wire logic [15:0]          calc_reading,
    input wire logic                 transient,
    input wire gas_out_pkg::health_s health,
    input wire logic [15:0]          analog_code,
    input wire logic                 rx_line,
    input wire logic                 tx_line
);
    logic [1:0]  baud;
    int unsigned low_cnt;
    int unsigned up_cnt;
    // baud is mirrored from apb writes since the checker cannot see the register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) baud <= 2'h0;
        else if (psel && penable && pwrite && paddr == gas_out_pkg::OFS_CTRL) baud <= pwdata[4:3];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_cnt <= 0;
        else low_cnt <= tx_line ? 0 : low_cnt + 1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) up_cnt <= 0;
        else if (up_cnt < 2) up_cnt <= up_cnt + 1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_fault_zero_out: assert property (health != 3'h0 |=> analog_code == 16'h0000)
        else $error("analog output not zero under fault");
    a_freeze_hold: assert property ((transient && health == 3'h0) [*2] |=> $stable(analog_code))
        else $error("analog output moved during transient");
    a_startup_level: assert property (up_cnt == 1 && health == 3'h0 |->
        analog_code == gas_out_pkg::ZERO_CODE_RST && tx_line)
        else $error("start-up level wrong");
    a_tx_bit_multiple: assert property ($rose(tx_line) |-> low_cnt % (BIT_CYCLES << baud) == 0)
        else $error("tx low run not whole bits");
    a_tx_max_low: assert property (low_cnt <= 9 * (BIT_CYCLES << baud))
        else $error("tx low longer than start plus data");
    a_pready_zero_wait: assert property (psel |-> pready)
        else $error("pready low");
    a_slverr_unmapped: assert property (psel && penable && paddr > gas_out_pkg::OFS_CAL |->
        pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_slverr_mapped: assert property (psel && penable && paddr <= gas_out_pkg::OFS_CAL
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped access");
endmodule
bind gas_reading_output_control gas_out_monitor #(
    .SEC_CYCLES(SEC_CYCLES),
    .BIT_CYCLES(BIT_CYCLES)
) mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .calc_reading(calc_reading), .transient(transient), .health(health),
    .analog_code(analog_code), .rx_line(rx_line), .tx_line(tx_line));

// [gas_host_model.sv]
// host instrument model: uart command sender and reply receiver
`timescale 1ns/1ps
module gas_host_model #(
    parameter int unsigned BIT_CYCLES = 16
) (
    input  wire logic pclk,
    input  wire logic tx_line,
    output logic      rx_line
);
    initial rx_line = 1'b1; // idle high
    // zero then span makes one calibration check; the host repeats it within a year
    // bsel picks one of four rates, each half the one before
    task automatic send_byte(input logic [7:0] b, input logic [1:0] bsel);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0}; // start low, lsb first, one stop, no parity
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            rx_line <= frame[i];
            repeat ((BIT_CYCLES << bsel) - 1) @(posedge pclk);
        end
    endtask
    task automatic get_byte(input logic [1:0] bsel, output logic [7:0] b, output logic ok);
        int unsigned n;
        int unsigned bl;
        bl = BIT_CYCLES << bsel;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (tx_line !== 1'b0 && n < 40 * bl) begin
            @(posedge pclk);
            n++;
        end
        // sample mid-bit so a one-cycle race at the edges cannot matter
        repeat (bl / 2) @(posedge pclk);
        if (tx_line !== 1'b0) return;
        for (int i = 0; i < 8; i++) begin
            repeat (bl) @(posedge pclk);
            b[i] = tx_line; // lsb first
        end
        repeat (bl) @(posedge pclk);
        ok = (tx_line === 1'b1); // one stop bit
    endtask
endmodule

// [test_gas_reading_output_control.sv]
// self-checking bench for the gas reading output control block
`timescale 1ns/1ps
module test_gas_reading_output_control;
    localparam int unsigned SEC  = 100;
    localparam int unsigned BITC = 16;
    logic                 pclk;
    logic                 presetn;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [11:0]          paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [15:0]          calc_reading;
    logic                 transient;
    gas_out_pkg::health_s health;
    logic [15:0]          analog_code;
    logic                 rx_line;
    logic                 tx_line;
    int                   err_count;
    int                   n_checks;
    int                   cyc;
    logic [31:0]          rd;
    logic                 slv;
    logic [7:0]           lo;
    logic [7:0]           hi;
    logic                 ok_lo;
    logic                 ok_hi;
    logic [11:0]          ra [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
    logic [31:0]          rv [5] = '{32'h0, 32'h800, 32'h2d, 32'h800, 32'h400};
    logic [15:0]          lim [4] = '{gas_out_pkg::LIMIT_100, gas_out_pkg::LIMIT_125,
                                      gas_out_pkg::LIMIT_150, gas_out_pkg::LIMIT_200};

    gas_reading_output_control #(.SEC_CYCLES(SEC), .BIT_CYCLES(BITC)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .calc_reading(calc_reading), .transient(transient), .health(health),
        .analog_code(analog_code), .rx_line(rx_line), .tx_line(tx_line));
    gas_host_model #(.BIT_CYCLES(BITC)) host (.pclk(pclk), .tx_line(tx_line), .rx_line(rx_line));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // whole run needs roughly 9500 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            $display("[FAIL] %0t timeout", $time);
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait count assumed; only the bench timeout ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic achk(input logic [15:0] e);
        repeat (3) @(posedge pclk);
        chk({16'h0, analog_code}, {16'h0, e});
    endtask
    task automatic query(input logic [1:0] bsel, input logic [15:0] e);
        fork
            host.send_byte(gas_out_pkg::CMD_READ, bsel);
            host.get_byte(bsel, lo, ok_lo);
        join
        host.get_byte(bsel, hi, ok_hi);
        chk({14'h0, ok_hi, ok_lo, hi, lo}, {14'h0, 2'b11, e});
    endtask
    task automatic wait_to(input int n);
        while (cyc < n) @(posedge pclk);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        calc_reading = 16'h01f4;
        transient = 1'b0;
        health = 3'h0;
        err_count = 0;
        n_checks = 0;
        cyc = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rchk(ra[i], rv[i]);
        rchk(12'h020, 32'h0);
        chk({31'h0, slv}, 32'h1);
        achk(16'h0800);
        rchk(gas_out_pkg::OFS_READING, 32'hf63c);
        query(2'h0, 16'hf63c);
        apb(1'b1, gas_out_pkg::OFS_WARM_LVL, 32'h0123);
        achk(16'h0123);
        apb(1'b1, gas_out_pkg::OFS_WARM_SECS, 32'h14);
        wait_to(6 + 20 * SEC - 20);
        achk(16'h0123);
        wait_to(6 + 20 * SEC + 20);
        achk(16'h09f4);
        calc_reading <= 16'h07d0;
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, gas_out_pkg::OFS_CTRL, 32'(s) << 1);
            rchk(gas_out_pkg::OFS_READING, {16'h0, lim[s]});
            achk(16'h0800 + lim[s]);
        end
        calc_reading <= 16'h012c;
        apb(1'b1, gas_out_pkg::OFS_CTRL, 32'h1);
        achk(16'h06d4);
        calc_reading <= 16'hfc18;
        achk(16'h0be8);
        rchk(gas_out_pkg::OFS_READING, 32'hfc18);
        apb(1'b1, gas_out_pkg::OFS_CTRL, 32'h0);
        calc_reading <= 16'h012c;
        achk(16'h092c);
        transient <= 1'b1;
        calc_reading <= 16'h0258;
        achk(16'h092c);
        rchk(gas_out_pkg::OFS_READING, 32'h012c);
        transient <= 1'b0;
        achk(16'h0a58);
        // fault must win even with a transient pending
        for (int i = 0; i < 3; i++) begin
            transient <= 1'b1;
            health <= 3'h1 << i;
            achk(16'h0000);
            rchk(gas_out_pkg::OFS_READING, 32'hf63c);
            health <= 3'h0;
            transient <= 1'b0;
            achk(16'h0a58);
        end
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, gas_out_pkg::OFS_CTRL, 32'(b) << 3);
            query(2'(b), 16'h0258);
        end
        apb(1'b1, gas_out_pkg::OFS_CTRL, 32'h0);
        calc_reading <= 16'h0064;
        repeat (4) @(posedge pclk);
        host.send_byte(gas_out_pkg::CMD_ZERO, 2'h0);
        calc_reading <= 16'h01f4;
        repeat (4) @(posedge pclk);
        // host refuses a span gas level outside ten to one hundred percent
        if (calc_reading >= 16'h0064 && calc_reading <= 16'h03e8) begin
            host.send_byte(gas_out_pkg::CMD_SPAN, 2'h0);
        end
        rchk(gas_out_pkg::OFS_CAL, 32'h01f40064);
        rchk(gas_out_pkg::OFS_STATUS, 32'h300);
        apb(1'b1, gas_out_pkg::OFS_STATUS, 32'h300);
        rchk(gas_out_pkg::OFS_STATUS, 32'h0);
        finish_test();
    end
endmodule
